/* design/twr_defines.svh */
// register map, field positions, reset values and timing counts
`ifndef TWR_DEFINES_SVH
`define TWR_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TWR_A_CTRL  8'h00
`define TWR_A_TBC   8'h04
`define TWR_A_WCTL  8'h08
`define TWR_A_FLAG  8'h0c
`define TWR_A_MASK1 8'h10
`define TWR_A_MASK2 8'h14
`define TWR_A_WAKE  8'h18
`define TWR_A_STAT  8'h1c
`define TWR_A_PULLH 8'h20
`define TWR_A_PULLD 8'h24
`define TWR_A_LVD   8'h28

// ****************************************
// field positions and write masks
// ****************************************
`define TWR_CTRL_GIE  6
`define TWR_CTRL_SRC  5
`define TWR_CTRL_EDGE 4
`define TWR_CTRL_PSE  3
`define TWR_WCTL_EN   7
`define TWR_WCTL_PSE  3
`define TWR_F_TB      0
`define TWR_F_IC      1
`define TWR_F_AD      6
`define TWR_WAKE_IC   6
`define TWR_WAKE_AD   5
`define TWR_ST_T      4
`define TWR_ST_P      3
`define TWR_WCTL_WM   8'h8f
`define TWR_MASK1_WM  8'he7
`define TWR_MASK2_WM  8'h30
`define TWR_FLAG_WM   8'h43
`define TWR_WAKE_WM   8'h60

// ****************************************
// reset values and vectors
// ****************************************
`define TWR_PULL_RST  8'hff
`define TWR_WCTL_RST  8'h80
`define TWR_VEC_IC    8'h06
`define TWR_VEC_TB    8'h09
`define TWR_VEC_AD    8'h30

// ****************************************
// times and derived cycle counts
// ****************************************
`define TWR_CLK_MHZ     100
`define TWR_START_MS    18
`define TWR_WDT_MS      18
`define TWR_WAKE_RC_CLK 34
`define TWR_HXT_MS      2
`define TWR_HXT_CLK     32
`define TWR_LOW_CRYSTAL_TWO_MODE_MS     500
`define TWR_OTH_US      150
`define TWR_START_CYC   (`TWR_START_MS * 1000 * `TWR_CLK_MHZ)
`define TWR_WDT_TICK_CYC ((`TWR_WDT_MS * 1000 * `TWR_CLK_MHZ) / 256)
`define TWR_WAKE_RC_CYC `TWR_WAKE_RC_CLK
`define TWR_WAKE_HXT_CYC (`TWR_HXT_MS * 1000 * `TWR_CLK_MHZ + `TWR_HXT_CLK)
`define TWR_WAKE_LOW_CRYSTAL_TWO_MODE_CYC (`TWR_LOW_CRYSTAL_TWO_MODE_MS * 1000 * `TWR_CLK_MHZ)
`define TWR_WAKE_OTH_CYC (`TWR_OTH_US * `TWR_CLK_MHZ)

`endif

/* design/twr_pkg.sv */
// types shared by the timer, watchdog, reset and wake-up block
package twr_pkg;

   typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE} twr_state_type;

   typedef enum logic [1:0] {OSC_RC, OSC_HXT, OSC_LOW_CRYSTAL_TWO_MODE, OSC_OTHER} twr_osc_type;

   // one-cycle instruction strobes from the core sequencer
   typedef struct packed {
      logic gie_set;
      logic gie_clr;
      logic wdt_clear;
      logic sleep;
   } twr_cmd_type;

   // branch request towards the core
   typedef struct packed {
      logic       req;
      logic [7:0] addr;
   } twr_vec_type;

endpackage : twr_pkg

/* design/twr_timer_wake.sv */
// time-base counter, watchdog, reset sequencing and sleep wake-up
//
// Behaviour
// - writing the time-base counter clears its prescaler count
// - watchdog-clear or sleep instruction clears watchdog and its prescaler
// - 8-bit counter steps by one each instruction cycle on internal source
// - instruction cycle is clock divided by 2, 4, 8 or 16 by option
// - external source counts one per pin edge of selected polarity
// - time-base counter stops while sleeping
// - watchdog runs on own oscillator, also in sleep, timeout resets
// - watchdog enable writable any time; bypassed period about 18 ms
// - reset on power-on, low reset pin, or enabled watchdog timeout
// - device stays in reset one start-up period, about 18 ms
// - reset zeroes program counter and puts port pins to input
// - pin or watchdog reset clears counter control except the global enable bit; power-on clears all
// - reset sets pull-high, pull-down and voltage-detect controls to ones
// - reset clears interrupt flag and both mask registers
// - sleep instruction powers down; watchdog cleared but keeps running
// - wake delay 34 clocks RC, 2 ms plus 32 high crystal, 500 ms
// - reset-pin or watchdog wake resets; T and P flags tell which
// - port-6 or conversion wake resumes; next instruction if interrupts off
// - enabled unmasked port-6 change branches to vector 06
// - overflow sets flag; with interrupts off execution just continues
// - counter prescaler off is 1:1, on gives 1:2 to 1:256
// - watchdog prescaler off is 1:1, on gives 1:2 to 1:256
// - edge select zero counts rising, one counts falling edges
// - enabled unmasked overflow sets flag and branches to vector 09
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "twr_defines.svh"

module twr_timer_wake
   import twr_pkg::*;
#(
   parameter int unsigned START_CYC     = `TWR_START_CYC,
   parameter int unsigned WDT_TICK_CYC  = `TWR_WDT_TICK_CYC,
   parameter int unsigned WAKE_HXT_CYC  = `TWR_WAKE_HXT_CYC,
   parameter int unsigned WAKE_LOW_CRYSTAL_TWO_MODE_CYC = `TWR_WAKE_LOW_CRYSTAL_TWO_MODE_CYC,
   parameter int unsigned WAKE_OTH_CYC  = `TWR_WAKE_OTH_CYC
) (
   // clock and power-on reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // core instruction strobes and options
   input  wire twr_cmd_type core_cmd_i,
   input  wire logic [1:0]  cycle_clock_select_option_i,
   input  wire twr_osc_type osc_mode_i,
   input  wire logic        watchdog_hardware_option_i,
   // pins and wake sources
   input  wire logic        reset_pin_n_i,
   input  wire logic        counter_pin_i,
   input  wire logic        port6_change_i,
   input  wire logic        conversion_done_i,
   // towards the core
   output logic             core_reset_o,
   output logic             pc_clear_o,
   output logic             ports_input_o,
   output logic             sleep_o,
   output logic             resume_o,
   output twr_vec_type      vector_o,
   output logic [7:0]       timebase_counter_o
);

   // ****************************************
   // declarations
   // ****************************************
   twr_state_type state_r;
   logic [31:0]   dly_r;
   logic [31:0]   wake_len;
   logic [7:0]    ctrl_r, tb_r, tpsc_r, wctl_r, wdt_r, wpsc_r;
   logic [7:0]    flag_r, mask1_r, mask2_r, wake_r, stat_r;
   logic [7:0]    pull_r [3];
   logic [15:0]   wdiv_r;
   logic [3:0]    cdiv_r;
   logic [2:0]    cp_s_r, rp_s_r;
   logic          cp_lvl_r, rp_lvl_r, ack_r, resume_r, wsrc_ic_r;
   twr_vec_type   vec_r;
   logic          dev_rst, run, bus_wr, tb_wr, cdiv_hit, cyc_en;
   logic          cp_rise, cp_fall, tb_src, tb_step, ovf;
   logic          wtick, wdt_step, wdt_en, wdt_to, wdt_clr, rst_evt;
   logic          gie, ic_set, ad_set, ic_wake, ad_wake, wake_done;
   logic [7:0]    wdat;

   // prescaler tap: fires when the low ratio+1 bits are all ones
   function automatic logic psc_hit(input logic [7:0] c, input logic [2:0] r);
      logic [7:0] m;
      m = 8'((9'h2 << r) - 9'h1);
      return (c & m) == m;
   endfunction : psc_hit

   // ****************************************
   // pin synchronisers
   // ****************************************
   // three stages; a level counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cp_s_r   <= 3'h0;
         cp_lvl_r <= 1'b0;
         rp_s_r   <= 3'h7;
         rp_lvl_r <= 1'b1;
      end else begin
         cp_s_r <= {cp_s_r[1:0], counter_pin_i};
         rp_s_r <= {rp_s_r[1:0], reset_pin_n_i};
         if (cp_s_r[1] == cp_s_r[2]) cp_lvl_r <= cp_s_r[2];
         if (rp_s_r[1] == rp_s_r[2]) rp_lvl_r <= rp_s_r[2];
      end
   end

   // pulse widths under two clocks are lost
   assign cp_rise = (cp_s_r[1] == cp_s_r[2]) & cp_s_r[2] & ~cp_lvl_r;
   assign cp_fall = (cp_s_r[1] == cp_s_r[2]) & ~cp_s_r[2] & cp_lvl_r;

   // ****************************************
   // wishbone slave
   // ****************************************
   // ack one cycle after the strobe; writes land on the ack edge
   always_ff @(posedge clk_i) begin
      if (rst_i) ack_r <= 1'b0;
      else ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
   end

   assign wb_ack_o = ack_r;
   assign bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
   assign wdat     = wb_dat_i[7:0];
   assign tb_wr    = bus_wr & (wb_adr_i == `TWR_A_TBC);

   // read data captured with the ack; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else begin
         unique case (wb_adr_i)
            `TWR_A_CTRL:  wb_dat_o <= {24'h0, ctrl_r};
            `TWR_A_TBC:   wb_dat_o <= {24'h0, tb_r};
            `TWR_A_WCTL:  wb_dat_o <= {24'h0, wctl_r};
            `TWR_A_FLAG:  wb_dat_o <= {24'h0, flag_r};
            `TWR_A_MASK1: wb_dat_o <= {24'h0, mask1_r};
            `TWR_A_MASK2: wb_dat_o <= {24'h0, mask2_r};
            `TWR_A_WAKE:  wb_dat_o <= {24'h0, wake_r};
            `TWR_A_STAT:  wb_dat_o <= {24'h0, stat_r[7:2], state_r};
            `TWR_A_PULLH: wb_dat_o <= {24'h0, pull_r[0]};
            `TWR_A_PULLD: wb_dat_o <= {24'h0, pull_r[1]};
            `TWR_A_LVD:   wb_dat_o <= {24'h0, pull_r[2]};
            default:      wb_dat_o <= 32'h0;
         endcase
      end
   end

   // ****************************************
   // reset, sleep and wake sequencer
   // ****************************************
   assign dev_rst   = rst_i | (state_r == ST_HOLD);
   assign run       = state_r == ST_RUN;
   assign rst_evt   = ~rp_lvl_r | wdt_to;
   assign ic_wake   = port6_change_i & wake_r[`TWR_WAKE_IC];
   assign ad_wake   = conversion_done_i & wake_r[`TWR_WAKE_AD];
   assign wake_done = (state_r == ST_WAKE) & (dly_r <= 32'h1) & ~rst_evt;

   // wake delay by oscillator mode
   always_comb begin
      unique case (osc_mode_i)
         OSC_RC:   wake_len = 32'(`TWR_WAKE_RC_CYC);
         OSC_HXT:  wake_len = 32'(WAKE_HXT_CYC);
         OSC_LOW_CRYSTAL_TWO_MODE: wake_len = 32'(WAKE_LOW_CRYSTAL_TWO_MODE_CYC);
         OSC_OTHER: wake_len = 32'(WAKE_OTH_CYC);
      endcase
   end

   // a reset event always wins and restarts the start-up period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_HOLD;
         dly_r   <= 32'(START_CYC);
      end else if (rst_evt) begin
         state_r <= ST_HOLD;
         dly_r   <= 32'(START_CYC);
      end else begin
         unique case (state_r)
            ST_HOLD: begin
               if (dly_r <= 32'h1) state_r <= ST_RUN;
               else dly_r <= dly_r - 32'h1;
            end
            ST_RUN: begin
               if (core_cmd_i.sleep) state_r <= ST_SLEEP;
            end
            ST_SLEEP: begin
               if (ic_wake | ad_wake) begin
                  state_r <= ST_WAKE;
                  dly_r   <= wake_len;
               end
            end
            ST_WAKE: begin
               if (dly_r <= 32'h1) state_r <= ST_RUN;
               else dly_r <= dly_r - 32'h1;
            end
         endcase
      end
   end

   // remember which source woke us, for the resume branch
   always_ff @(posedge clk_i) begin
      if (dev_rst) wsrc_ic_r <= 1'b0;
      else if (state_r == ST_SLEEP && (ic_wake | ad_wake)) wsrc_ic_r <= ic_wake;
   end

   // core-facing reset view
   assign core_reset_o  = state_r == ST_HOLD;
   assign pc_clear_o    = state_r == ST_HOLD;
   assign ports_input_o = state_r == ST_HOLD;
   assign sleep_o       = (state_r == ST_SLEEP) | (state_r == ST_WAKE);

   // ****************************************
   // time-out and power-down flags
   // ****************************************
   // power-on and a run-state watchdog-clear set both; a pin reset leaves them as they were
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_r <= 8'h18;
      end else if (wdt_to) begin
         stat_r[`TWR_ST_T] <= 1'b0;
         stat_r[`TWR_ST_P] <= run;
      end else if (run && core_cmd_i.sleep) begin
         stat_r[`TWR_ST_T] <= 1'b1;
         stat_r[`TWR_ST_P] <= 1'b0;
      end else if (run && core_cmd_i.wdt_clear) begin
         stat_r[`TWR_ST_T] <= 1'b1;
         stat_r[`TWR_ST_P] <= 1'b1;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   assign gie = ctrl_r[`TWR_CTRL_GIE];

   // the global enable survives pin and watchdog resets
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= 8'h0;
      end else if (dev_rst) begin
         ctrl_r <= ctrl_r & (8'h1 << `TWR_CTRL_GIE);
      end else begin
         if (bus_wr && wb_adr_i == `TWR_A_CTRL) ctrl_r <= wdat;
         if (core_cmd_i.gie_set) ctrl_r[`TWR_CTRL_GIE] <= 1'b1;
         if (core_cmd_i.gie_clr) ctrl_r[`TWR_CTRL_GIE] <= 1'b0;
      end
   end

   // watchdog enable may change at any time
   always_ff @(posedge clk_i) begin
      if (dev_rst) wctl_r <= `TWR_WCTL_RST;
      else if (bus_wr && wb_adr_i == `TWR_A_WCTL) wctl_r <= wdat & `TWR_WCTL_WM;
   end

   // masks and wake enables
   always_ff @(posedge clk_i) begin
      if (dev_rst) begin
         mask1_r <= 8'h0;
         mask2_r <= 8'h0;
         wake_r  <= 8'h0;
      end else if (bus_wr) begin
         if (wb_adr_i == `TWR_A_MASK1) mask1_r <= wdat & `TWR_MASK1_WM;
         if (wb_adr_i == `TWR_A_MASK2) mask2_r <= wdat & `TWR_MASK2_WM;
         if (wb_adr_i == `TWR_A_WAKE)  wake_r  <= wdat & `TWR_WAKE_WM;
      end
   end

   // pull and voltage-detect controls, all ones out of reset
   always_ff @(posedge clk_i) begin
      if (dev_rst) begin
         for (int i = 0; i < 3; i++) pull_r[i] <= `TWR_PULL_RST;
      end else if (bus_wr) begin
         if (wb_adr_i == `TWR_A_PULLH) pull_r[0] <= wdat;
         if (wb_adr_i == `TWR_A_PULLD) pull_r[1] <= wdat;
         if (wb_adr_i == `TWR_A_LVD)   pull_r[2] <= wdat;
      end
   end

   // ****************************************
   // interrupt flags
   // ****************************************
   assign ic_set = port6_change_i & mask1_r[`TWR_F_IC];
   assign ad_set = conversion_done_i & mask1_r[`TWR_F_AD];

   // a hardware set in the same cycle as a software clear wins
   always_ff @(posedge clk_i) begin
      if (dev_rst) begin
         flag_r <= 8'h0;
      end else begin
         flag_r <= ((bus_wr && wb_adr_i == `TWR_A_FLAG) ? (wdat & `TWR_FLAG_WM) : flag_r)
                   | (8'(ovf) << `TWR_F_TB)
                   | (8'(ic_set) << `TWR_F_IC)
                   | (8'(ad_set) << `TWR_F_AD);
      end
   end

   // ****************************************
   // instruction cycle divider
   // ****************************************
   // the oscillator driver is off in sleep, so cycles only count in run
   assign cdiv_hit = cdiv_r == 4'((5'h2 << cycle_clock_select_option_i) - 5'h1);
   assign cyc_en   = cdiv_hit & run;

   always_ff @(posedge clk_i) begin
      if (rst_i || cdiv_hit) cdiv_r <= 4'h0;
      else cdiv_r <= cdiv_r + 4'h1;
   end

   // ****************************************
   // time-base counter
   // ****************************************
   assign tb_src  = run & (ctrl_r[`TWR_CTRL_SRC]
                   ? (ctrl_r[`TWR_CTRL_EDGE] ? cp_fall : cp_rise)
                   : cyc_en);
   assign tb_step = tb_src & (~ctrl_r[`TWR_CTRL_PSE]
                   | psc_hit(tpsc_r, ctrl_r[2:0]));
   assign ovf     = tb_step & (tb_r == 8'hff);

   always_ff @(posedge clk_i) begin
      if (dev_rst) begin
         tb_r   <= 8'h0;
         tpsc_r <= 8'h0;
      end else if (tb_wr) begin
         tb_r   <= wdat;
         tpsc_r <= 8'h0;
      end else if (tb_src) begin
         tpsc_r <= tpsc_r + 8'h1;
         if (tb_step) tb_r <= tb_r + 8'h1;
      end
   end

   assign timebase_counter_o = tb_r;

   // ****************************************
   // watchdog
   // ****************************************
   // free-running tick stands in for the on-chip rc oscillator
   assign wtick = wdiv_r == 16'(WDT_TICK_CYC - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i || wtick) wdiv_r <= 16'h0;
      else wdiv_r <= wdiv_r + 16'h1;
   end

   assign wdt_en   = watchdog_hardware_option_i & wctl_r[`TWR_WCTL_EN];
   assign wdt_step = wtick & (~wctl_r[`TWR_WCTL_PSE]
                    | psc_hit(wpsc_r, wctl_r[2:0]));
   assign wdt_to   = wdt_en & wdt_step & (wdt_r == 8'hff) & ~dev_rst;
   assign wdt_clr  = run & (core_cmd_i.wdt_clear | core_cmd_i.sleep);

   // counts in run, sleep and wake alike
   always_ff @(posedge clk_i) begin
      if (dev_rst || wdt_clr || !wdt_en) begin
         wdt_r  <= 8'h0;
         wpsc_r <= 8'h0;
      end else if (wtick) begin
         wpsc_r <= wpsc_r + 8'h1;
         if (wdt_step) wdt_r <= wdt_r + 8'h1;
      end
   end

   // ****************************************
   // branch requests and resume
   // ****************************************
   // lowest vector first when events coincide
   always_ff @(posedge clk_i) begin
      if (dev_rst) begin
         vec_r    <= '0;
         resume_r <= 1'b0;
      end else begin
         vec_r.req <= 1'b0;
         resume_r  <= wake_done;
         if (run && gie && ic_set) begin
            vec_r <= '{req: 1'b1, addr: `TWR_VEC_IC};
         end else if (run && gie && ovf && mask1_r[`TWR_F_TB]) begin
            vec_r <= '{req: 1'b1, addr: `TWR_VEC_TB};
         end else if (run && gie && ad_set) begin
            vec_r <= '{req: 1'b1, addr: `TWR_VEC_AD};
         end else if (wake_done && gie && wsrc_ic_r && mask1_r[`TWR_F_IC]) begin
            vec_r <= '{req: 1'b1, addr: `TWR_VEC_IC};
         end else if (wake_done && gie && !wsrc_ic_r && mask1_r[`TWR_F_AD]) begin
            vec_r <= '{req: 1'b1, addr: `TWR_VEC_AD};
         end
      end
   end

   assign vector_o = vec_r;
   assign resume_o = resume_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   tb_wr_psc_a: assert property (tb_wr && !dev_rst |=> tpsc_r == 8'h0)
      else $error("counter write left prescaler count");
   wdt_clear_a: assert property (wdt_clr && !rst_evt |=> wdt_r == 8'h0 && wpsc_r == 8'h0)
      else $error("watchdog not cleared by instruction");
   tb_step_a: assert property (cyc_en && !tb_wr && !rst_evt && ctrl_r[5:3] == 3'b000
      |=> tb_r == 8'($past(tb_r) + 8'h1))
      else $error("counter did not step on cycle");
   cyc_div_a: assert property (cdiv_hit && cycle_clock_select_option_i == 2'b00
      && $stable(cycle_clock_select_option_i) |=> !cdiv_hit
      ##1 (cdiv_hit || cycle_clock_select_option_i != 2'b00))
      else $error("divide by two cycle wrong");
   sleep_stop_a: assert property (state_r == ST_SLEEP && !tb_wr ##1 state_r == ST_SLEEP
      |-> $stable(tb_r))
      else $error("counter moved in sleep");
   wdt_reset_a: assert property (wdt_to |=> state_r == ST_HOLD && dly_r == 32'(START_CYC))
      else $error("watchdog timeout did not reset");
   ctrl_keep_a: assert property (wdt_to |=> ##1 ctrl_r[5:0] == 6'h0 && !ctrl_r[7]
      && ctrl_r[6] == $past(ctrl_r[6]))
      else $error("control register reset wrong");
   pull_rst_a: assert property (state_r == ST_HOLD |=> pull_r[0] == 8'hff
      && pull_r[2] == 8'hff)
      else $error("pull controls not set in reset");
   flag_rst_a: assert property (state_r == ST_HOLD |=> flag_r == 8'h0 && mask1_r == 8'h0)
      else $error("flags or masks not cleared");
   ovf_flag_a: assert property (ovf && !tb_wr && !rst_evt |=> flag_r[0] && tb_r == 8'h0)
      else $error("overflow wrap or flag missing");
   ic_vec_a: assert property (run && gie && ic_set && !rst_evt
      |=> vector_o.req && vector_o.addr == 8'h06)
      else $error("input change branch missing");
   wake_rc_a: assert property (state_r == ST_SLEEP && ic_wake && !rst_evt
      && osc_mode_i == OSC_RC |=> dly_r == 32'd34)
      else $error("rc wake delay wrong");

   sleep_wake_c: cover property (state_r == ST_SLEEP ##1 state_r == ST_WAKE);
   wdt_to_c:     cover property (wdt_to);
   ovf_vec_c:    cover property (vector_o.req && vector_o.addr == 8'h09);
   resume_c:     cover property (resume_o && !vector_o.req);

endmodule : twr_timer_wake

/* verif/tb_twr_timer_wake.sv */
// self-checking bench for the timer, watchdog, reset and wake block
`timescale 1ns/10ps
module tb_twr_timer_wake
   import twr_pkg::*;
   ;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hw = 0, pin = 0, p6 = 0, go = 0;
   logic [1:0]  opt = 0, op = 0;
   logic [7:0]  adr = 0, q, v, e8, cnt;
   logic [31:0] dat = 0, rdat;
   logic        ack, crst, pcc, prt, slp, res;
   twr_cmd_type cmd_w;
   logic        rpin = 1, adc = 0;
   logic [3:0]  sel = 4'h1;
   twr_osc_type osc = OSC_RC;
   twr_vec_type vec;
   int          fail_count = 0, checked = 0, cyc_n = 0, seed = 65530, i, n, t, per;

   always #5 clk_i = ~clk_i;
   // hang guard, well above the few thousand cycles the tests need
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 30000) begin
         fail_count++;
         close_out();
      end
   end

   twr_core_model twr_core_model_i (.clk_i(clk_i), .core_reset_i(crst), .go_i(go), .op_i(op),
      .core_cmd_o(cmd_w));
   twr_timer_wake #(.START_CYC(50), .WDT_TICK_CYC(4), .WAKE_HXT_CYC(20), .WAKE_LOW_CRYSTAL_TWO_MODE_CYC(20),
      .WAKE_OTH_CYC(20)) twr_timer_wake_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .core_cmd_i(cmd_w), .cycle_clock_select_option_i(opt),
      .osc_mode_i(osc), .watchdog_hardware_option_i(hw), .reset_pin_n_i(rpin),
      .counter_pin_i(pin), .port6_change_i(p6), .conversion_done_i(adc), .core_reset_o(crst),
      .pc_clear_o(pcc), .ports_input_o(prt), .sleep_o(slp), .resume_o(res), .vector_o(vec),
      .timebase_counter_o(cnt));

   task close_out;
      $display("counts: %0d checked, %0d failed", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   // classic cycle held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s = 4'h1);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= s;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat[7:0];
      cyc <= 0; stb <= 0;
      @(posedge clk_i);
   endtask : wb
   // each level held far longer than one instruction cycle
   task automatic pulse(input int k, input logic lvl);
      repeat (k) begin
         pin <= ~lvl; repeat (40) @(posedge clk_i);
         pin <= lvl; repeat (40) @(posedge clk_i);
      end
   endtask : pulse
   task automatic issue(input logic [1:0] o);
      op <= o; go <= 1; @(posedge clk_i);
      go <= 0; @(posedge clk_i);
   endtask : issue
   function automatic logic [7:0] rst_val(input int a);
      case (a)
         8: return 8'h80;
         32, 36, 40: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction : rst_val

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
      `CHK(pcc, 1'b1)
      `CHK(prt, 1'b1)
      n = 0;
      while (crst !== 1'b0) begin @(posedge clk_i); n++; end
      `CHK(n >= 45 && n <= 55, 1'b1)
      // counter and status skipped: they move or are not reset-cleared
      for (i = 0; i < 12; i++) if (i != 1 && i != 7) begin
         wb(0, 8'(i * 4), 0);
         `CHK(q, rst_val(i * 4))
      end
      $display("reset test done");
      for (t = 0; t < 4; t++) begin
         opt <= 2'(t);
         e8 = 8'(($random(seed) & 1) ? 8 | ($random(seed) & 3) : 0);
         wb(1, 8'h00, e8);
         per = (2 << t) * (e8[3] ? 2 << e8[2:0] : 1);
         v = cnt; while (cnt === v) @(posedge clk_i);
         v = cnt; repeat (per * 4) @(posedge clk_i);
         `CHK(cnt, 8'(v + 4))
      end
      $display("count test done");
      for (t = 0; t < 2; t++) begin
         pin <= t[0]; wb(1, 8'h00, 8'(8'h20 | t << 4)); wb(1, 8'h04, 8'hff);
         n = 2 + ($random(seed) & 3); pulse(n, t[0]);
         `CHK(cnt, 8'(8'hff + n))
      end
      $display("edge test done");
      wb(1, 8'h00, 8'h00); wb(1, 8'h18, 8'h40);
      issue(2'd3); @(posedge clk_i);
      `CHK(slp, 1'b1)
      v = cnt; repeat (50) @(posedge clk_i);
      `CHK(cnt, v)
      p6 <= 1; @(posedge clk_i); p6 <= 0; n = 0;
      while (res !== 1'b1) begin @(posedge clk_i); n++; end
      `CHK(n >= 33 && n <= 40, 1'b1)
      $display("sleep test done");
      // a write with byte lane 0 off must leave the register alone
      wb(1, 8'h20, 8'h5a, 4'h0); wb(0, 8'h20, 0);
      `CHK(q, 8'hff)
      issue(2'd0); wb(1, 8'h10, 8'h03);
      p6 <= 1; @(posedge clk_i); p6 <= 0; @(posedge clk_i);
      `CHK(vec, 9'h106)
      wb(1, 8'h04, 8'hff);
      while (vec.req !== 1'b1) @(posedge clk_i);
      `CHK(vec.addr, 8'h09)
      $display("vector test done");
      // interrupts off: conversion wake resumes without a branch
      issue(2'd1); wb(1, 8'h18, 8'h20); osc <= OSC_HXT; issue(2'd3);
      adc <= 1; @(posedge clk_i); adc <= 0; n = 0;
      while (res !== 1'b1) begin @(posedge clk_i); n++; end
      `CHK(n, 21)
      `CHK(vec.req, 1'b0)
      $display("conversion wake test done");
      issue(2'd0); rpin <= 0;
      while (crst !== 1'b1) @(posedge clk_i);
      rpin <= 1;
      while (crst !== 1'b0) @(posedge clk_i);
      wb(0, 8'h00, 0);
      `CHK(q, 8'h40)
      wb(0, 8'h1c, 0);
      `CHK(q[4:3], 2'b10)
      $display("reset pin test done");
      hw <= 1; wb(1, 8'h08, 8'h80); issue(2'd2); n = 0;
      while (crst !== 1'b1) begin @(posedge clk_i); n++; end
      `CHK(n >= 1000 && n <= 1100, 1'b1)
      wb(0, 8'h1c, 0);
      `CHK(q[4], 1'b0)
      $display("watchdog test done");
      close_out();
   end
endmodule : tb_twr_timer_wake

/* verif/twr_core_model.sv */
// core sequencer model issuing one-cycle instruction strobes
`timescale 1ns/10ps
module twr_core_model
   import twr_pkg::*;
(
   // clock and core hold
   input  wire logic       clk_i,
   input  wire logic       core_reset_i,
   // request from bench
   input  wire logic       go_i,
   input  wire logic [1:0] op_i,
   // strobes to block
   output twr_cmd_type     core_cmd_o = '0
);
   // a held core fetches nothing, so no strobe is issued during reset
   always_ff @(posedge clk_i) begin
      core_cmd_o <= '0;
      if (go_i && !core_reset_i) begin
         core_cmd_o <= twr_cmd_type'(4'h8 >> op_i);
      end
   end
endmodule : twr_core_model
